// *** logic/asp_source.sv ***
// Notes on behaviour
// - At most 32 channels per sample period.
// - Each sample sent with its sideband fields.
// - Frame is two sub-frames, X then Y.
// - Block of 192 frames starts with Z.
// - Every channel pair is its own block.
// - Block spans 192 periods of all channels.
// - Even channels Z in first period, else X.
// - Odd channels always carry Y.
// - Unused slots carry zeros, normal preambles.
// - Sink output stalls while its ready low.
// - Read address ready after valid data taken.
// - Read valid only with valid data, response.
// - Control reset active low, port silent then.
// - Control clock enable active high gates port.
`timescale 1ns/100ps
module asp_source (
	input  wire logic                      core_clk,     // 200 MHz clock.
	input  wire logic                      reset_n,      // Asynchronous reset, active low.
	asp_stream_if.src                      link,         // Stream and control port.
	input  wire asp_pkg::asp_cnt_t         cfg_channels, // Channel slots per period.
	input  wire asp_pkg::asp_cnt_t         cfg_active,   // Slots with real audio.
	input  wire logic                      run,          // Allow streaming.
	input  wire logic [asp_pkg::SMP_W-1:0] smp_data,     // Next real sample.
	input  wire logic                      smp_valid,    // Sample offered.
	output logic                           smp_ready,    // Sample taken this cycle.
	input  wire logic                      ctl_en,       // Control clock enable.
	input  wire logic                      rd_req,       // Start a control read.
	input  wire asp_pkg::asp_addr_t        rd_addr,      // Address for the read.
	output logic                           rd_busy,      // Read in progress.
	output logic                           rd_done,      // Read finished, one cycle.
	output logic [asp_pkg::DATA_W-1:0]     rd_data,      // Data of the last read.
	output asp_pkg::asp_resp_t             rd_resp       // Response of the last read.
);
	typedef enum {RD_IDLE, RD_ADDR, RD_DATA} asp_rd_state_t;

	asp_rd_state_t             rd_state;
	asp_pkg::asp_addr_t        araddr;
	asp_pkg::asp_ch_t          slot;
	asp_pkg::asp_blk_t         frame;
	asp_pkg::asp_cnt_t         chans;
	asp_pkg::asp_cnt_t         active;
	asp_pkg::asp_cnt_t         next_chans;
	asp_pkg::asp_cnt_t         next_active;
	asp_pkg::asp_cnt_t         eff_chans;
	asp_pkg::asp_cnt_t         eff_active;
	logic [asp_pkg::SMP_W-1:0] tdata;
	asp_pkg::asp_ch_t          tchan;
	asp_pkg::asp_pre_t         tpre;
	logic                      tlast;
	logic                      tvalid;
	logic                      load;
	logic                      real_slot;
	logic                      last_slot;
	logic                      step;

	// Configuration is clamped so that a bad setting cannot break pairing.
	always_comb
	begin
		next_chans = cfg_channels;
		if (next_chans > asp_pkg::MAX_CH)
			next_chans = asp_pkg::MAX_CH;
		if (next_chans < asp_pkg::MIN_CH)
			next_chans = asp_pkg::MIN_CH;
		next_chans[0] = 1'b0;
		next_active = (cfg_active > next_chans) ? next_chans : cfg_active;
	end

	// Settings take effect only at a period boundary.
	assign eff_chans  = (slot == '0) ? next_chans : chans;
	assign eff_active = (slot == '0) ? next_active : active;

	assign load      = run && (!tvalid || link.tready);
	assign real_slot = {1'b0, slot} < eff_active;
	assign last_slot = {1'b0, slot} == (eff_chans - asp_pkg::asp_cnt_t'(1));
	assign step      = load && (!real_slot || smp_valid);
	assign smp_ready = load && real_slot;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			chans  <= asp_pkg::MIN_CH;
			active <= '0;
		end
		else if (step && slot == '0)
		begin
			chans  <= next_chans;
			active <= next_active;
		end
	end

	// Slot walks the channels of one period; frame counts periods in a block.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			slot  <= '0;
			frame <= '0;
		end
		else if (step)
		begin
			if (last_slot)
			begin
				slot  <= '0;
				frame <= (frame == asp_pkg::BLK_LAST) ? '0 : frame + 1'b1;
			end
			else
				slot <= slot + 1'b1;
		end
	end

	// All pairs share one frame counter, so every pair restarts its block together.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tdata  <= '0;
			tchan  <= '0;
			tpre   <= asp_pkg::PRE_X;
			tlast  <= 1'b0;
			tvalid <= 1'b0;
		end
		else if (step)
		begin
			tdata  <= real_slot ? smp_data : '0;
			tchan  <= slot;
			tpre   <= asp_pkg::pre_for(slot, frame == '0);
			tlast  <= last_slot;
			tvalid <= 1'b1;
		end
		else if (link.tready)
			tvalid <= 1'b0;
	end

	assign link.tdata  = tdata;
	assign link.tchan  = tchan;
	assign link.tpre   = tpre;
	assign link.tlast  = tlast;
	assign link.tvalid = tvalid;

	// Control read master; every handshake needs the clock enable as well.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_state <= RD_IDLE;
			araddr   <= '0;
		end
		else
		begin
			unique case (rd_state)
				RD_IDLE:
				begin
					if (rd_req)
					begin
						araddr   <= rd_addr;
						rd_state <= RD_ADDR;
					end
				end
				RD_ADDR:
				begin
					if (ctl_en && link.arready)
						rd_state <= RD_DATA;
				end
				RD_DATA:
				begin
					if (ctl_en && link.rvalid)
						rd_state <= RD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_done <= 1'b0;
			rd_data <= '0;
			rd_resp <= asp_pkg::RESP_OKAY;
		end
		else
		begin
			rd_done <= 1'b0;
			if (rd_state == RD_DATA && ctl_en && link.rvalid)
			begin
				rd_done <= 1'b1;
				rd_data <= link.rdata;
				rd_resp <= link.rresp;
			end
		end
	end

	assign link.araddr  = araddr;
	assign link.arvalid = (rd_state == RD_ADDR);
	assign link.rready  = (rd_state == RD_DATA);
	assign link.aclken  = ctl_en;
	assign rd_busy      = (rd_state != RD_IDLE);

endmodule // asp_source

// *** logic/asp_pkg.sv ***
package asp_pkg;
	localparam int SMP_W        = 24;
	localparam int CH_W         = 5;
	localparam int CNT_W        = 6;
	localparam int BLK_W        = 8;
	localparam int PRE_W        = 2;
	localparam int WORD_W       = SMP_W + CH_W + PRE_W + 1;
	localparam int FIFO_DEPTH   = 16;
	localparam int BLOCK_FRAMES = 192;
	localparam int ADDR_W       = 4;
	localparam int DATA_W       = 32;

	typedef logic [CNT_W-1:0]  asp_cnt_t;
	typedef logic [CH_W-1:0]   asp_ch_t;
	typedef logic [BLK_W-1:0]  asp_blk_t;
	typedef logic [PRE_W-1:0]  asp_pre_t;
	typedef logic [ADDR_W-1:0] asp_addr_t;
	typedef logic [1:0]        asp_resp_t;

	localparam asp_cnt_t  MAX_CH   = 6'h20;
	localparam asp_cnt_t  MIN_CH   = 6'h02;
	localparam asp_blk_t  BLK_LAST = asp_blk_t'(BLOCK_FRAMES - 1);

	// Preamble codes carried beside every sample.
	localparam asp_pre_t  PRE_X = 2'h0;
	localparam asp_pre_t  PRE_Y = 2'h1;
	localparam asp_pre_t  PRE_Z = 2'h2;

	localparam asp_addr_t ADDR_STATUS = 4'h0;
	localparam asp_addr_t ADDR_COUNT  = 4'h4;
	localparam int        ST_ERR_BIT   = 0;
	localparam int        ST_FRAME_LSB = 8;
	localparam asp_resp_t RESP_OKAY   = 2'h0;
	localparam asp_resp_t RESP_SLVERR = 2'h2;

	function automatic asp_pre_t pre_for(input asp_ch_t ch, input logic first);
		if (ch[0])
			return PRE_Y;
		else if (first)
			return PRE_Z;
		else
			return PRE_X;
	endfunction
endpackage

// *** logic/asp_stream_if.sv ***
`timescale 1ns/100ps
interface asp_stream_if;
	logic [asp_pkg::SMP_W-1:0]  tdata;   // Sample, zero in unused slots.
	asp_pkg::asp_ch_t           tchan;   // Channel index of the sample.
	asp_pkg::asp_pre_t          tpre;    // Preamble code.
	logic                       tlast;   // Last channel of a sample period.
	logic                       tvalid;  // Source holds a sample.
	logic                       tready;  // Sink takes it.
	asp_pkg::asp_addr_t         araddr;  // Control read address.
	logic                       arvalid; // Read address valid.
	logic                       arready; // Read address taken.
	logic [asp_pkg::DATA_W-1:0] rdata;   // Read data.
	asp_pkg::asp_resp_t         rresp;   // Read response.
	logic                       rvalid;  // Read data valid.
	logic                       rready;  // Read data taken.
	logic                       aclken;  // Control port clock enable.

	modport src (
		output tdata, tchan, tpre, tlast, tvalid, araddr, arvalid, rready, aclken,
		input  tready, arready, rdata, rresp, rvalid
	);
	modport snk (
		input  tdata, tchan, tpre, tlast, tvalid, araddr, arvalid, rready, aclken,
		output tready, arready, rdata, rresp, rvalid
	);
endinterface

// *** logic/asp_sink.sv ***
`timescale 1ns/100ps
module asp_fifo #(
	parameter int WIDTH = 32, // Word width.
	parameter int DEPTH = 16  // Word count, a power of two.
) (
	input  wire logic             core_clk,  // Clock.
	input  wire logic             reset_n,   // Asynchronous reset, active low.
	input  wire logic [WIDTH-1:0] in_data,   // Word in.
	input  wire logic             in_valid,  // Word offered.
	output logic                  in_ready,  // Room for a word.
	output logic [WIDTH-1:0]      out_data,  // Oldest word.
	output logic                  out_valid, // FIFO not empty.
	input  wire logic             out_ready  // Oldest word taken.
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;

	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge core_clk)
	begin
		if (in_valid && in_ready)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_ptr <= wr_ptr + 1'b1;
			if (out_valid && out_ready)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // asp_fifo

module asp_sink (
	input  wire logic                  core_clk,  // 200 MHz clock.
	input  wire logic                  reset_n,   // Asynchronous reset, active low.
	asp_stream_if.snk                  link,      // Stream and control port.
	output logic [asp_pkg::SMP_W-1:0]  out_data,  // Sample.
	output asp_pkg::asp_ch_t           out_chan,  // Channel index.
	output asp_pkg::asp_pre_t          out_pre,   // Preamble code.
	output logic                       out_last,  // Last channel of a period.
	output logic                       out_valid, // Sample held.
	input  wire logic                  out_ready, // Downstream takes it.
	output logic                       seq_error  // Sticky sequence error.
);
	logic [asp_pkg::WORD_W-1:0] f_data;
	logic                       f_valid;
	logic                       f_ready;
	logic                       take;
	logic                       bad;
	logic                       ar_hs;
	logic                       clr_err;
	logic                       ctl_up;
	asp_pkg::asp_ch_t           exp_ch;
	asp_pkg::asp_blk_t          frame;
	logic [asp_pkg::DATA_W-1:0] count;
	logic [asp_pkg::DATA_W-1:0] rdata;
	asp_pkg::asp_resp_t         rresp;
	logic                       rvalid;

	asp_fifo #(
		.WIDTH(asp_pkg::WORD_W),
		.DEPTH(asp_pkg::FIFO_DEPTH)
	) asp_fifo_i (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.in_data  ({link.tdata, link.tchan, link.tpre, link.tlast}),
		.in_valid (link.tvalid),
		.in_ready (link.tready),
		.out_data (f_data),
		.out_valid(f_valid),
		.out_ready(f_ready)
	);

	// The output register only reloads when downstream frees it.
	assign f_ready = !out_valid || out_ready;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			out_valid <= 1'b0;
			{out_data, out_chan, out_pre, out_last} <= '0;
		end
		else if (f_ready)
		begin
			out_valid <= f_valid;
			if (f_valid)
				{out_data, out_chan, out_pre, out_last} <= f_data;
		end
	end

	// Sequence check on the incoming stream against the shared block count.
	assign take = link.tvalid && link.tready;
	assign bad  = take && (link.tchan != exp_ch ||
		link.tpre != asp_pkg::pre_for(link.tchan, frame == '0));

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			exp_ch <= '0;
			frame  <= '0;
			count  <= '0;
		end
		else if (take)
		begin
			count <= count + 1'b1;
			if (link.tlast)
			begin
				exp_ch <= '0;
				frame  <= (frame == asp_pkg::BLK_LAST) ? '0 : frame + 1'b1;
			end
			else
				exp_ch <= exp_ch + 1'b1;
		end
	end

	// A fresh error wins over a clearing status read in the same cycle.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			seq_error <= 1'b0;
		else if (bad)
			seq_error <= 1'b1;
		else if (clr_err)
			seq_error <= 1'b0;
	end

	// The port stays silent through reset and for one edge after it.
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			ctl_up <= 1'b0;
		else
			ctl_up <= 1'b1;
	end

	assign link.arready = ctl_up && link.aclken && !rvalid;
	assign ar_hs        = link.arvalid && link.arready;
	assign clr_err      = ar_hs && link.araddr == asp_pkg::ADDR_STATUS;

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= asp_pkg::RESP_OKAY;
		end
		else if (ar_hs)
		begin
			rvalid <= 1'b1;
			rdata  <= '0;
			rresp  <= asp_pkg::RESP_OKAY;
			if (link.araddr == asp_pkg::ADDR_STATUS)
			begin
				rdata[asp_pkg::ST_ERR_BIT] <= seq_error;
				rdata[asp_pkg::ST_FRAME_LSB +: asp_pkg::BLK_W] <= frame;
			end
			else if (link.araddr == asp_pkg::ADDR_COUNT)
				rdata <= count;
			else
				rresp <= asp_pkg::RESP_SLVERR;
		end
		else if (rvalid && link.rready && link.aclken)
			rvalid <= 1'b0;
	end

	assign link.rdata  = rdata;
	assign link.rresp  = rresp;
	assign link.rvalid = rvalid;

endmodule // asp_sink

// *** testbench/asp_stream_properties.sv ***
`timescale 1ns/100ps
module asp_stream_properties (
	input wire logic                       core_clk, // Clock.
	input wire logic                       reset_n,  // Reset, active low.
	input wire logic [asp_pkg::SMP_W-1:0]  tdata,    // Sample.
	input wire asp_pkg::asp_ch_t           tchan,    // Channel index.
	input wire asp_pkg::asp_pre_t          tpre,     // Preamble code.
	input wire logic                       tlast,    // Last slot.
	input wire logic                       tvalid,   // Sample valid.
	input wire logic                       tready,   // Sample taken.
	input wire logic                       arvalid,  // Address valid.
	input wire logic                       arready,  // Address taken.
	input wire logic [asp_pkg::DATA_W-1:0] rdata,    // Read data.
	input wire logic                       rvalid,   // Read valid.
	input wire logic                       rready,   // Read taken.
	input wire logic                       aclken    // Control enable.
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Period within the block, counted on the wire so that it survives pauses.
	logic [7:0] per;
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			per <= 8'h00;
		else if (tvalid && tready && tlast)
			per <= (per == 8'hbf) ? 8'h00 : per + 8'h01;
	end

	sequence s_addr;
		arvalid && arready;
	endsequence
	sequence s_data;
		##1 rvalid;
	endsequence

	a_odd_pre: assert property (
		tvalid && tchan[0] |-> tpre == asp_pkg::PRE_Y)
		else $error("odd slot preamble wrong");
	a_even_pre: assert property (
		tvalid && !tchan[0] |-> tpre == ((per == 8'h00) ? asp_pkg::PRE_Z : asp_pkg::PRE_X))
		else $error("even slot preamble wrong");
	a_stall_hold: assert property (
		tvalid && !tready |=> tvalid && $stable({tdata, tchan, tpre, tlast}))
		else $error("stalled sample changed");
	a_last_pair: assert property (
		tvalid && tlast |-> tchan[0])
		else $error("period ends on even slot");
	a_read_answer: assert property (
		s_addr |-> s_data)
		else $error("read answer late");
	a_busy_refuse: assert property (
		rvalid |-> !arready)
		else $error("address taken while data pending");
	a_enable_gate: assert property (
		!aclken |-> !arready)
		else $error("address taken while disabled");
	a_data_hold: assert property (
		rvalid && !(rready && aclken) |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_reset_quiet: assert property (
		$rose(reset_n) |-> !arready)
		else $error("address taken at reset release");
endmodule // asp_stream_properties

// *** testbench/tb_audio_stream_preamble_framing.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
	begin \
		n_checks++; \
		if ((got) !== (ex)) \
		begin \
			$display("BAD %s exp %h got %h", nm, ex, got); \
			error_cnt++; \
		end \
	end
module tb_audio_stream_preamble_framing;
	logic                       core_clk = 1'b0;
	logic                       reset_n  = 1'b0;
	asp_pkg::asp_cnt_t          cfg_ch, cfg_act;
	logic                       run, smp_valid, smp_ready, ctl_en, rd_req, rd_busy, rd_done;
	logic [23:0]                smp_data, o_data, ed;
	asp_pkg::asp_addr_t         rd_addr;
	logic [asp_pkg::DATA_W-1:0] rd_data;
	asp_pkg::asp_resp_t         rd_resp;
	asp_pkg::asp_ch_t           o_chan;
	asp_pkg::asp_pre_t          o_pre, ep;
	logic                       o_last, o_valid, out_ready, seq_err, seq_err2, hold;
	logic [1:0]                 cyc;
	int                         error_cnt = 0, n_checks = 0, n_out = 0, n_take = 0;
	int                         slot, per, ch, act;
	logic [23:0]                q[$];

	asp_stream_if link ();
	asp_stream_if link2 ();
	always #2.5 core_clk = ~core_clk;

	asp_source asp_source_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
		.cfg_channels(cfg_ch), .cfg_active(cfg_act), .run(run), .smp_data(smp_data),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .ctl_en(ctl_en), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_busy(rd_busy), .rd_done(rd_done), .rd_data(rd_data),
		.rd_resp(rd_resp));
	asp_sink asp_sink_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
		.out_data(o_data), .out_chan(o_chan), .out_pre(o_pre), .out_last(o_last),
		.out_valid(o_valid), .out_ready(out_ready), .seq_error(seq_err));
	// This sink faces the bench, which breaks the preamble order on purpose.
	asp_sink asp_sink_i2 (.core_clk(core_clk), .reset_n(reset_n), .link(link2),
		.out_data(), .out_chan(), .out_pre(), .out_last(), .out_valid(),
		.out_ready(1'b1), .seq_error(seq_err2));
	asp_stream_properties asp_stream_properties_i (.core_clk(core_clk), .reset_n(reset_n),
		.tdata(link.tdata), .tchan(link.tchan), .tpre(link.tpre), .tlast(link.tlast),
		.tvalid(link.tvalid), .tready(link.tready), .arvalid(link.arvalid),
		.arready(link.arready), .rdata(link.rdata), .rvalid(link.rvalid),
		.rready(link.rready), .aclken(link.aclken));

	task end_sim;
		$display("Errors %0d of %0d checks", error_cnt, n_checks);
		if (error_cnt == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task step;
		@(posedge core_clk);
		#1;
	endtask

	task do_reset(input asp_pkg::asp_cnt_t c, input asp_pkg::asp_cnt_t a, input int ec,
		input int ea);
		reset_n = 1'b0;
		run = 1'b0;
		cfg_ch = c;
		cfg_act = a;
		ch = ec;
		act = ea;
		repeat (20) step();
		reset_n = 1'b1;
		slot = 0;
		per = 0;
		n_take = 0;
		q.delete();
	endtask

	task wait_out(input int n);
		int t;
		int k;
		t = n_out + n;
		for (k = 0; k < 20000 && n_out < t; k++)
			step();
		`CHK("progress", 1'b1, n_out >= t)
	endtask

	task wait_done;
		int k;
		for (k = 0; k < 20 && rd_done !== 1'b1; k++)
			step();
	endtask

	task rd(input asp_pkg::asp_addr_t a);
		rd_addr = a;
		rd_req = 1'b1;
		step();
		rd_req = 1'b0;
		wait_done();
	endtask

	// Handshakes are sampled half a cycle early, where the design's outputs have settled.
	always @(negedge core_clk)
	begin
		if (reset_n && smp_valid && smp_ready)
		begin
			q.push_back(smp_data);
			@(posedge core_clk);
			smp_data <= #1 smp_data + 24'h000101;
		end
	end

	always @(posedge core_clk)
	begin
		cyc <= #1 cyc + 2'h1;
		out_ready <= #1 !hold && (cyc != 2'h0);
	end

	always @(negedge core_clk)
	begin
		if (reset_n && link.tvalid && link.tready)
			n_take++;
		if (reset_n && o_valid && out_ready)
		begin
			ed = (slot < act) ? q.pop_front() : 24'h000000;
			ep = (slot % 2) ? asp_pkg::PRE_Y : ((per == 0) ? asp_pkg::PRE_Z : asp_pkg::PRE_X);
			`CHK("chan", asp_pkg::asp_ch_t'(slot), o_chan)
			`CHK("pre", ep, o_pre)
			`CHK("data", ed, o_data)
			`CHK("last", slot == ch - 1, o_last)
			n_out++;
			slot = (slot == ch - 1) ? 0 : slot + 1;
			if (slot == 0)
				per = (per == 191) ? 0 : per + 1;
		end
	end

	// The tests need under a thousand cycles; the limit of 40000 cycles leaves a wide margin.
	initial
	begin
		#200000;
		error_cnt++;
		end_sim();
	end

	initial
	begin
		{run, rd_req, rd_addr, cyc, out_ready, smp_data} = '0;
		{smp_valid, ctl_en, hold} = 3'h7;
		{link2.tdata, link2.tchan, link2.tpre, link2.tlast, link2.tvalid} = '0;
		{link2.araddr, link2.arvalid, link2.rready, link2.aclken} = '0;
		do_reset(6'h02, 6'h02, 2, 2);
		run = 1'b1;
		repeat (40) step();
		`CHK("tready", 1'b0, link.tready)
		`CHK("taken", 17, n_take)
		hold = 1'b0;
		wait_out(386);
		run = 1'b0;
		repeat (40) step();
		rd(asp_pkg::ADDR_COUNT);
		`CHK("done", 1'b1, rd_done)
		`CHK("count", n_take, rd_data)
		`CHK("resp", asp_pkg::RESP_OKAY, rd_resp)
		rd(asp_pkg::ADDR_STATUS);
		`CHK("status", 1'b0, rd_data[asp_pkg::ST_ERR_BIT])
		rd(4'h8);
		`CHK("unmapped", asp_pkg::RESP_SLVERR, rd_resp)
		`CHK("unmapped data", 32'h00000000, rd_data)
		ctl_en = 1'b0;
		rd(asp_pkg::ADDR_COUNT);
		`CHK("gated", 1'b1, rd_busy)
		ctl_en = 1'b1;
		wait_done();
		`CHK("ungated", 1'b1, rd_done)
		// Dropping the enable while the answer waits must freeze that answer.
		rd_addr = asp_pkg::ADDR_COUNT;
		rd_req = 1'b1;
		step();
		rd_req = 1'b0;
		step();
		ctl_en = 1'b0;
		repeat (4) step();
		`CHK("held data", 1'b1, link.rvalid)
		`CHK("held count", n_take, link.rdata)
		ctl_en = 1'b1;
		wait_done();
		`CHK("released", 1'b1, rd_done)
		do_reset(6'h08, 6'h06, 8, 6);
		run = 1'b1;
		wait_out(24);
		do_reset(6'h28, 6'h28, 32, 32);
		run = 1'b1;
		wait_out(64);
		do_reset(6'h03, 6'h01, 2, 1);
		run = 1'b1;
		wait_out(8);
		`CHK("seq ok", 1'b0, seq_err)
		link2.tpre = asp_pkg::PRE_Y;
		link2.tvalid = 1'b1;
		step();
		link2.tvalid = 1'b0;
		repeat (6) step();
		`CHK("seq fault", 1'b1, seq_err2)
		// A status read reports the fault and clears it.
		link2.aclken = 1'b1;
		link2.rready = 1'b1;
		link2.arvalid = 1'b1;
		step();
		link2.arvalid = 1'b0;
		`CHK("fault flag", 1'b1, link2.rdata[asp_pkg::ST_ERR_BIT])
		step();
		`CHK("fault cleared", 1'b0, seq_err2)
		end_sim();
	end
endmodule // tb_audio_stream_preamble_framing
